//--- inc/trf_readout_map.vh
`ifndef TRF_READOUT_MAP_VH
`define TRF_READOUT_MAP_VH

// ----------------------------------------------------------------
// serial format
// ----------------------------------------------------------------
`define TRF_LANES 20
`define TRF_SLICE_BITS 34
`define TRF_BITCNT_W 6
`define TRF_LAST_BIT 6'h21
`define TRF_MODULES 16
`define TRF_MODWORD_W 25
`define TRF_XCNT_W 12
`define TRF_XCNT_LANES 12
`define TRF_REMOTE_W 56
`define TRF_ETH_W 4
`define TRF_MISS_W 8
`define TRF_MODSUM_W 55
`define TRF_PAIR_W 68
`define TRF_FRAME_W 523

// ----------------------------------------------------------------
// frame field positions (low bit of each field)
// ----------------------------------------------------------------
`define TRF_F_MODWORD 0
`define TRF_F_REMOTE 400
`define TRF_F_ETH 456
`define TRF_F_MISS 460
`define TRF_F_MODSUM 468

// ----------------------------------------------------------------
// history ring and trigger queue
// ----------------------------------------------------------------
`define TRF_ADDR_W 8
`define TRF_RING_DEPTH 256
`define TRF_LATENCY 8'h20
`define TRF_QPTR_W 2
`define TRF_QCNT_W 3
`define TRF_QDEPTH 3'h4
`define TRF_SLICE_W 3
`define TRF_GAP_W 8

// ----------------------------------------------------------------
// serializer states
// ----------------------------------------------------------------
`define TRF_ST_IDLE 3'h0
`define TRF_ST_LOAD 3'h1
`define TRF_ST_SHIFT 3'h2
`define TRF_ST_PARITY 3'h3
`define TRF_ST_GAP 3'h4

`endif

//--- rtl/trf_ring_mem.v
`timescale 1ns/1ps
`default_nettype none

module trf_ring_mem #(
    parameter WIDTH = 523,
    parameter DEPTH = 256,
    parameter AW = 8
) (
    // clock
    input wire clk,
    // write side
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [WIDTH-1:0] wr_data,
    // read side
    input wire [AW-1:0] rd_addr,
    output reg [WIDTH-1:0] rd_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];

    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule // trf_ring_mem

`default_nettype wire

//--- rtl/trf_readout_formatter.v
`timescale 1ns/1ps
`default_nettype none
`include "trf_readout_map.vh"

module trf_readout_formatter #(
    parameter QDEPTH = 4,
    parameter RING_DEPTH = `TRF_RING_DEPTH
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // timing
    input wire level_one_accept,
    input wire crossing_count_clear,
    // per-crossing input data
    input wire [`TRF_MODULES*`TRF_MODWORD_W-1:0] sum_module_words,
    input wire [`TRF_REMOTE_W-1:0] remote_sums,
    input wire [`TRF_ETH_W-1:0] total_energy_hits,
    input wire [`TRF_MISS_W-1:0] missing_energy_hits,
    input wire [`TRF_MODSUM_W-1:0] module_sums,
    // configuration
    input wire system_summing,
    input wire [`TRF_SLICE_W-1:0] slice_count,
    input wire [`TRF_GAP_W-1:0] gap_length,
    input wire clear_errors,
    // event data link
    output reg [`TRF_LANES-1:0] event_lane_bits,
    output reg event_transfer_valid_strobe,
    // interest data link
    output reg [`TRF_LANES-1:0] interest_lane_bits,
    output reg interest_transfer_valid_strobe,
    // status
    output reg queue_overrun_flag,
    output reg sticky_overrun_flag,
    output reg [`TRF_XCNT_W-1:0] crossing_counter_value
);

    // ----------------------------------------------------------------
    // history write side and crossing counter
    // ----------------------------------------------------------------
    reg [`TRF_ADDR_W-1:0] wr_ptr;
    wire [`TRF_FRAME_W-1:0] frame_in;
    wire [`TRF_ADDR_W-1:0] accept_addr;
    wire [1:0] push_ovf;
    wire [1:0] q_empty;
    wire [`TRF_LANES-1:0] lane_out [0:1];
    wire [1:0] strobe_out;

    assign frame_in = {module_sums, missing_energy_hits, total_energy_hits, remote_sums, sum_module_words};
    // the accepted crossing sits a fixed latency behind the live write pointer
    assign accept_addr = wr_ptr - `TRF_LATENCY;

    always @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr <= {`TRF_ADDR_W{1'b0}};
            crossing_counter_value <= {`TRF_XCNT_W{1'b0}};
        end else begin
            wr_ptr <= wr_ptr + 8'h01;
            if (crossing_count_clear) begin
                crossing_counter_value <= {`TRF_XCNT_W{1'b0}};
            end else begin
                crossing_counter_value <= crossing_counter_value + 12'h001;
            end
        end
    end

    // ----------------------------------------------------------------
    // overrun flags
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            queue_overrun_flag <= 1'b0;
            sticky_overrun_flag <= 1'b0;
        end else begin
            // set wins over both clears so an event-path overflow is never lost
            if (push_ovf[0]) begin
                queue_overrun_flag <= 1'b1;
            end else if (q_empty[0]) begin
                queue_overrun_flag <= 1'b0;
            end
            if (push_ovf[0]) begin
                sticky_overrun_flag <= 1'b1;
            end else if (clear_errors) begin
                sticky_overrun_flag <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // registered link outputs; the link shares clk, so no clock crossing is built
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            event_lane_bits <= {`TRF_LANES{1'b0}};
            interest_lane_bits <= {`TRF_LANES{1'b0}};
            event_transfer_valid_strobe <= 1'b0;
            interest_transfer_valid_strobe <= 1'b0;
        end else begin
            event_lane_bits <= lane_out[0];
            interest_lane_bits <= lane_out[1];
            event_transfer_valid_strobe <= strobe_out[0];
            interest_transfer_valid_strobe <= strobe_out[1];
        end
    end

    // ----------------------------------------------------------------
    // readout paths: 0 is event data, 1 is region of interest
    // ----------------------------------------------------------------
    genvar p;
    genvar l;
    generate
        for (p = 0; p < 2; p = p + 1) begin : g_path
            wire path_on;
            wire push;
            wire pop;
            wire [`TRF_FRAME_W-1:0] rd_frame;
            wire [`TRF_SLICE_W-1:0] n_slices;
            wire [`TRF_PAIR_W-1:0] pair_hi;
            wire [`TRF_PAIR_W-1:0] pair_mid;
            wire [`TRF_LANES*`TRF_SLICE_BITS-1:0] slice_word;
            reg [`TRF_ADDR_W-1:0] q_addr [0:QDEPTH-1];
            reg [`TRF_XCNT_W-1:0] q_xcnt [0:QDEPTH-1];
            reg [`TRF_QPTR_W-1:0] q_wp;
            reg [`TRF_QPTR_W-1:0] q_rp;
            reg [`TRF_QCNT_W-1:0] q_cnt;
            reg [2:0] state;
            reg [`TRF_BITCNT_W-1:0] bitcnt;
            reg [`TRF_SLICE_W-1:0] slice;
            reg [`TRF_ADDR_W-1:0] rd_addr;
            reg [`TRF_XCNT_W-1:0] cur_xcnt;
            reg [`TRF_LANES*`TRF_SLICE_BITS-1:0] shreg;
            reg [`TRF_LANES-1:0] par;
            reg [`TRF_GAP_W-1:0] gapcnt;
            // separate ring and queue per path so neither stalls the other
            trf_ring_mem #(
                .WIDTH(`TRF_FRAME_W),
                .DEPTH(RING_DEPTH),
                .AW(`TRF_ADDR_W)
            ) u_ring (
                .clk(clk),
                .wr_en(1'b1),
                .wr_addr(wr_ptr),
                .wr_data(frame_in),
                .rd_addr(rd_addr),
                .rd_data(rd_frame)
            );

            assign path_on = (p == 0) ? 1'b1 : system_summing;
            assign n_slices = (p == 0) ? slice_count : 3'h1;
            assign push = level_one_accept & path_on;
            assign pop = (state == `TRF_ST_IDLE) && (q_cnt != 3'h0);
            assign push_ovf[p] = push && (q_cnt == `TRF_QDEPTH) && !pop;
            assign q_empty[p] = (q_cnt == 3'h0) && (state == `TRF_ST_IDLE);

            // slice layout, same for both paths
            assign pair_hi = {missing_energy_hits_slot(rd_frame), rd_frame[`TRF_F_REMOTE +: `TRF_REMOTE_W]};
            assign pair_mid = {queue_overrun_flag, cur_xcnt, rd_frame[`TRF_F_MODSUM +: `TRF_MODSUM_W]};
            for (l = 0; l < `TRF_MODULES; l = l + 1) begin : g_lane
                if (l < `TRF_XCNT_LANES) begin : g_xcnt
                    assign slice_word[l*`TRF_SLICE_BITS +: `TRF_SLICE_BITS] =
                        {8'h00, cur_xcnt[l], rd_frame[l*`TRF_MODWORD_W +: `TRF_MODWORD_W]};
                end else begin : g_plain
                    assign slice_word[l*`TRF_SLICE_BITS +: `TRF_SLICE_BITS] =
                        {9'h000, rd_frame[l*`TRF_MODWORD_W +: `TRF_MODWORD_W]};
                end
            end
            assign slice_word[16*`TRF_SLICE_BITS +: `TRF_PAIR_W] = pair_hi;
            assign slice_word[18*`TRF_SLICE_BITS +: `TRF_PAIR_W] = pair_mid;
            for (l = 0; l < `TRF_LANES; l = l + 1) begin : g_out
                assign lane_out[p][l] = (state == `TRF_ST_PARITY) ? ~par[l] :
                    (state == `TRF_ST_SHIFT) ? shreg[l*`TRF_SLICE_BITS + `TRF_SLICE_BITS - 1] : 1'b0;
            end
            assign strobe_out[p] = (state == `TRF_ST_SHIFT) || (state == `TRF_ST_PARITY);
            always @(posedge clk) begin
                if (!rst_n) begin
                    q_wp <= {`TRF_QPTR_W{1'b0}};
                    q_rp <= {`TRF_QPTR_W{1'b0}};
                    q_cnt <= 3'h0;
                end else begin
                    if (push && (q_cnt != `TRF_QDEPTH || pop)) begin
                        q_addr[q_wp] <= accept_addr;
                        q_xcnt[q_wp] <= crossing_counter_value;
                        q_wp <= q_wp + 2'h1;
                    end
                    if (pop) begin
                        q_rp <= q_rp + 2'h1;
                    end
                    if (push && !pop && q_cnt != `TRF_QDEPTH) begin
                        q_cnt <= q_cnt + 3'h1;
                    end else if (pop && !push) begin
                        q_cnt <= q_cnt - 3'h1;
                    end
                end
            end

            always @(posedge clk) begin
                if (!rst_n) begin
                    state <= `TRF_ST_IDLE;
                    bitcnt <= {`TRF_BITCNT_W{1'b0}};
                    slice <= 3'h0;
                    rd_addr <= {`TRF_ADDR_W{1'b0}};
                    cur_xcnt <= {`TRF_XCNT_W{1'b0}};
                    shreg <= {`TRF_LANES*`TRF_SLICE_BITS{1'b0}};
                    par <= {`TRF_LANES{1'b0}};
                    gapcnt <= {`TRF_GAP_W{1'b0}};
                end else begin
                    case (state)
                        `TRF_ST_IDLE: begin
                            if (pop) begin
                                rd_addr <= q_addr[q_rp];
                                cur_xcnt <= q_xcnt[q_rp];
                                slice <= 3'h0;
                                par <= {`TRF_LANES{1'b0}};
                                state <= `TRF_ST_LOAD;
                            end
                        end
                        `TRF_ST_LOAD: begin
                            // one cycle for the registered ring read
                            if (bitcnt == 6'h01) begin
                                shreg <= slice_word;
                                rd_addr <= rd_addr + 8'h01;
                                slice <= slice + 3'h1;
                                bitcnt <= 6'h00;
                                state <= `TRF_ST_SHIFT;
                            end else begin
                                bitcnt <= 6'h01;
                            end
                        end
                        `TRF_ST_SHIFT: begin
                            par <= par ^ lane_out[p];
                            if (bitcnt == `TRF_LAST_BIT) begin
                                bitcnt <= 6'h00;
                                if (slice < n_slices) begin
                                    // next slice was prefetched, so the strobe has no break
                                    shreg <= slice_word;
                                    rd_addr <= rd_addr + 8'h01;
                                    slice <= slice + 3'h1;
                                end else begin
                                    state <= `TRF_ST_PARITY;
                                end
                            end else begin
                                bitcnt <= bitcnt + 6'h01;
                                shreg <= shreg << 1;
                            end
                        end
                        `TRF_ST_PARITY: begin
                            gapcnt <= gap_length;
                            state <= `TRF_ST_GAP;
                        end
                        `TRF_ST_GAP: begin
                            if (gapcnt == 8'h00) begin
                                state <= `TRF_ST_IDLE;
                            end else begin
                                gapcnt <= gapcnt - 8'h01;
                            end
                        end
                        default: begin
                            state <= `TRF_ST_IDLE;
                        end
                    endcase
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // hit bits kept raw so each can be recovered individually
    // ----------------------------------------------------------------
    function [`TRF_ETH_W+`TRF_MISS_W-1:0] missing_energy_hits_slot;
        input [`TRF_FRAME_W-1:0] f;
        begin
            missing_energy_hits_slot = {f[`TRF_F_MISS +: `TRF_MISS_W], f[`TRF_F_ETH +: `TRF_ETH_W]};
        end
    endfunction

endmodule // trf_readout_formatter

`default_nettype wire

//--- tb/trf_props.sv
`timescale 1ns/1ps
`default_nettype none
module trf_props (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // controls
    input wire logic level_one_accept,
    input wire logic crossing_count_clear,
    input wire logic system_summing,
    input wire logic [2:0] slice_count,
    input wire logic [7:0] gap_length,
    input wire logic clear_errors,
    // status and strobes
    input wire logic event_transfer_valid_strobe,
    input wire logic interest_transfer_valid_strobe,
    input wire logic queue_overrun_flag,
    input wire logic sticky_overrun_flag,
    input wire logic [11:0] crossing_counter_value
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [9:0] evt_hi;
    logic [9:0] intr_hi;
    logic [9:0] evt_lo;
    logic [3:0] recent;
    logic [8:0] evt_len;
    // slice count zero behaves as one
    assign evt_len = (slice_count == 3'h0) ? 9'h023 : 9'h022 * slice_count + 9'h001;
    always @(posedge clk) begin
        if (!rst_n) begin
            evt_hi <= 10'h000;
            intr_hi <= 10'h000;
            evt_lo <= 10'h000;
            recent <= 4'h0;
        end else begin
            evt_hi <= event_transfer_valid_strobe ? evt_hi + 10'h001 : 10'h000;
            intr_hi <= interest_transfer_valid_strobe ? intr_hi + 10'h001 : 10'h000;
            // saturates so a long idle line is recognisable
            evt_lo <= event_transfer_valid_strobe ? 10'h000 : evt_lo + {9'h000, evt_lo != 10'h3ff};
            recent <= {recent[2:0], level_one_accept};
        end
    end
    property p_cnt_step;
        // the edge that ends reset still holds the counter at zero
        rst_n && !crossing_count_clear |=> crossing_counter_value == $past(crossing_counter_value) + 12'h001;
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("counter did not step");
    property p_cnt_clear;
        crossing_count_clear |=> crossing_counter_value == 12'h000;
    endproperty
    a_cnt_clear: assert property (p_cnt_clear) else $error("counter not cleared");
    property p_sticky_hold;
        sticky_overrun_flag && !clear_errors |=> sticky_overrun_flag;
    endproperty
    a_sticky_hold: assert property (p_sticky_hold) else $error("sticky flag dropped");
    property p_sticky_set;
        $rose(queue_overrun_flag) |-> sticky_overrun_flag;
    endproperty
    a_sticky_set: assert property (p_sticky_set) else $error("sticky flag not set");
    property p_evt_len;
        $fell(event_transfer_valid_strobe) |-> evt_hi == {1'b0, evt_len};
    endproperty
    a_evt_len: assert property (p_evt_len) else $error("event frame length wrong");
    property p_intr_len;
        $fell(interest_transfer_valid_strobe) |-> intr_hi == 10'h023;
    endproperty
    a_intr_len: assert property (p_intr_len) else $error("interest frame length wrong");
    property p_evt_gap;
        $rose(event_transfer_valid_strobe) |-> evt_lo >= {2'b00, gap_length} + 10'h002;
    endproperty
    a_evt_gap: assert property (p_evt_gap) else $error("event gap too short");
    property p_evt_answer;
        level_one_accept && recent == 4'h0 && evt_lo == 10'h3ff |-> ##[4:5] $rose(event_transfer_valid_strobe);
    endproperty
    a_evt_answer: assert property (p_evt_answer) else $error("event frame late");
    property p_intr_answer;
        level_one_accept && system_summing && recent == 4'h0 && evt_lo == 10'h3ff
            |-> ##[4:5] $rose(interest_transfer_valid_strobe);
    endproperty
    a_intr_answer: assert property (p_intr_answer) else $error("interest frame late");
endmodule // trf_props
bind trf_readout_formatter trf_props trf_props_inst (.clk(clk), .rst_n(rst_n),
    .level_one_accept(level_one_accept), .crossing_count_clear(crossing_count_clear),
    .system_summing(system_summing), .slice_count(slice_count), .gap_length(gap_length),
    .clear_errors(clear_errors), .event_transfer_valid_strobe(event_transfer_valid_strobe),
    .interest_transfer_valid_strobe(interest_transfer_valid_strobe),
    .queue_overrun_flag(queue_overrun_flag), .sticky_overrun_flag(sticky_overrun_flag),
    .crossing_counter_value(crossing_counter_value));
`default_nettype wire

//--- tb/trf_link_rx.sv
`timescale 1ns/1ps
`default_nettype none
module trf_link_rx (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // serial link
    input wire logic [19:0] lane_bits,
    input wire logic strobe,
    // captured frame
    output logic [679:0] first_slice,
    output logic [9:0] last_len,
    output logic [19:0] parity_ok,
    output logic [7:0] frames
);
    logic [9:0] pos;
    logic [19:0] acc;
    always @(posedge clk) begin
        if (!rst_n) begin
            pos <= 10'h000;
            acc <= 20'h00000;
            frames <= 8'h00;
            last_len <= 10'h000;
            parity_ok <= 20'h00000;
        end else if (strobe) begin
            pos <= pos + 10'h001;
            acc <= acc ^ lane_bits;
            // totals, crossing bits and hit bits are all read from slice 0
            for (int n = 0; n < 20; n++) begin
                if (pos < 10'h022) first_slice[n * 34 + 33 - pos] <= lane_bits[n];
            end
        end else if (pos != 10'h000) begin
            last_len <= pos;
            parity_ok <= acc;
            frames <= frames + 8'h01;
            pos <= 10'h000;
            acc <= 20'h00000;
        end
    end
endmodule // trf_link_rx
`default_nettype wire

//--- tb/trf_readout_formatter_tb.sv
`timescale 1ns/1ps
`default_nettype none
module trf_readout_formatter_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic level_one_accept = 1'b0;
    logic crossing_count_clear = 1'b0;
    logic [399:0] sum_module_words = '0;
    logic [55:0] remote_sums = '0;
    logic [3:0] total_energy_hits = 4'h0;
    logic [7:0] missing_energy_hits = 8'h00;
    logic [54:0] module_sums = '0;
    logic system_summing = 1'b1;
    logic [2:0] slice_count = 3'h1;
    logic [7:0] gap_length = 8'h06;
    logic clear_errors = 1'b0;
    logic [19:0] event_lane_bits, interest_lane_bits, evt_par, intr_par;
    logic event_transfer_valid_strobe, interest_transfer_valid_strobe;
    logic queue_overrun_flag, sticky_overrun_flag;
    logic [11:0] crossing_counter_value, acc_xcnt;
    logic [679:0] evt_slice, intr_slice;
    logic [9:0] evt_len, intr_len;
    logic [7:0] evt_frames, intr_frames;
    logic [15:0] cyc = 16'h0000;
    logic [15:0] acc_t;
    int n_errors = 0;
    int checks = 0;
    always #10 clk = ~clk;
    trf_readout_formatter trf_readout_formatter_inst (.clk(clk), .rst_n(rst_n),
        .level_one_accept(level_one_accept), .crossing_count_clear(crossing_count_clear),
        .sum_module_words(sum_module_words), .remote_sums(remote_sums),
        .total_energy_hits(total_energy_hits), .missing_energy_hits(missing_energy_hits),
        .module_sums(module_sums), .system_summing(system_summing), .slice_count(slice_count),
        .gap_length(gap_length), .clear_errors(clear_errors), .event_lane_bits(event_lane_bits),
        .event_transfer_valid_strobe(event_transfer_valid_strobe), .interest_lane_bits(interest_lane_bits),
        .interest_transfer_valid_strobe(interest_transfer_valid_strobe),
        .queue_overrun_flag(queue_overrun_flag), .sticky_overrun_flag(sticky_overrun_flag),
        .crossing_counter_value(crossing_counter_value));
    trf_link_rx evt_rx (.clk(clk), .rst_n(rst_n), .lane_bits(event_lane_bits),
        .strobe(event_transfer_valid_strobe), .first_slice(evt_slice), .last_len(evt_len),
        .parity_ok(evt_par), .frames(evt_frames));
    trf_link_rx intr_rx (.clk(clk), .rst_n(rst_n), .lane_bits(interest_lane_bits),
        .strobe(interest_transfer_valid_strobe), .first_slice(intr_slice), .last_len(intr_len),
        .parity_ok(intr_par), .frames(intr_frames));
    // inputs during cycle c are a pure function of c
    always @(posedge clk) begin
        cyc <= cyc + 16'h0001;
        for (int n = 0; n < 16; n++) sum_module_words[n * 25 +: 25] <= {9'(n), cyc + 16'h0001};
        remote_sums <= {40'h0, cyc + 16'h0001};
        module_sums <= {39'h0, ~(cyc + 16'h0001)};
        total_energy_hits <= cyc[3:0] + 4'h1;
        missing_energy_hits <= (cyc[7:0] + 8'h01) ^ 8'h5a;
    end
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [679:0] exp_slice(input logic [15:0] t, input logic [11:0] b, input logic ov);
        logic [679:0] e;
        e = '0;
        for (int n = 0; n < 16; n++) e[n * 34 +: 34] = {8'h00, (n < 12) ? b[n] : 1'b0, 9'(n), t};
        e[544 +: 68] = {t[7:0] ^ 8'h5a, t[3:0], 40'h0, t};
        e[612 +: 68] = {ov, b, 39'h0, ~t};
        return e;
    endfunction
    task automatic finish_test;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [679:0] got, input logic [679:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic fire(input int k);
        // sample settled values mid-cycle, then raise the accept on the next edge
        @(negedge clk);
        acc_t = cyc - 16'h001f;
        acc_xcnt = crossing_counter_value + 12'h001;
        @(posedge clk);
        level_one_accept <= 1'b1;
        repeat (k) @(posedge clk);
        level_one_accept <= 1'b0;
    endtask
    task automatic wait_frames(input logic [7:0] e, input logic [7:0] r);
        int i;
        i = 0;
        while ((evt_frames !== e || intr_frames !== r) && i < 4000) begin
            @(negedge clk);
            i++;
        end
        if (i >= 4000) begin
            n_errors++;
            finish_test();
        end
    endtask
    task automatic s_single;
        fire(1);
        wait_frames(8'h01, 8'h01);
        check(evt_slice, exp_slice(acc_t, acc_xcnt, 1'b0));
        check(evt_par, 20'hfffff);
        check(evt_len, 10'h023);
        check(intr_slice, exp_slice(acc_t, acc_xcnt, 1'b0));
        check(intr_par, 20'hfffff);
    endtask
    task automatic s_multi;
        @(posedge clk);
        slice_count <= 3'h3;
        fire(2);
        wait_frames(8'h03, 8'h03);
        check(evt_len, 10'h067);
        check(intr_len, 10'h023);
        check(evt_slice, exp_slice(acc_t + 16'h0001, acc_xcnt + 12'h001, 1'b0));
    endtask
    task automatic s_overrun;
        int i;
        @(posedge clk);
        slice_count <= 3'h7;
        fire(7);
        @(negedge clk);
        check({queue_overrun_flag, sticky_overrun_flag}, 2'h3);
        i = 0;
        while ((queue_overrun_flag !== 1'b0 || event_transfer_valid_strobe !== 1'b0) && i < 4000) begin
            @(negedge clk);
            i++;
        end
        if (i >= 4000) begin
            n_errors++;
            finish_test();
        end
        check(evt_slice[19 * 34 + 33], 1'b1);
        check({queue_overrun_flag, sticky_overrun_flag}, 2'h1);
        @(posedge clk);
        clear_errors <= 1'b1;
        @(posedge clk);
        clear_errors <= 1'b0;
        @(negedge clk);
        check(sticky_overrun_flag, 1'b0);
    endtask
    task automatic s_no_interest;
        logic [7:0] e, r;
        repeat (300) @(posedge clk);
        e = evt_frames;
        r = intr_frames;
        // a slice count of zero is sent as one slice
        slice_count <= 3'h0;
        system_summing <= 1'b0;
        fire(1);
        wait_frames(e + 8'h01, r);
        check(intr_frames, r);
        check(evt_slice, exp_slice(acc_t, acc_xcnt, 1'b0));
        check(evt_len, 10'h023);
        @(posedge clk);
        system_summing <= 1'b1;
        crossing_count_clear <= 1'b1;
        @(posedge clk);
        crossing_count_clear <= 1'b0;
        @(negedge clk);
        check(crossing_counter_value, 12'h000);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        check({event_lane_bits, interest_lane_bits, event_transfer_valid_strobe,
            interest_transfer_valid_strobe, queue_overrun_flag, sticky_overrun_flag}, '0);
        rst_n <= 1'b1;
        repeat (1100) @(posedge clk);
        s_single();
        s_multi();
        s_overrun();
        s_no_interest();
        finish_test();
    end
endmodule // trf_readout_formatter_tb
`default_nettype wire
